// ---- rtl/reset_sequence_supply_monitor.sv ----
// reset sequencer, supply monitor flags and AXI4-Lite register slave
// Overview of operation
// - three reset sources: external pin pulse, low-supply detector, watchdog.
// - every source drives the pin; pin stays low through the whole delay.
// - after reset the core fetches its vector from the two top addresses.
// - phases run in order: active, fixed delay, vector fetch.
// - delay is 256 or 4096 cycles, chosen by a configuration strap.
// - vector fetch lasts exactly two cycles before normal execution.
// - reset pin is input plus open-drain low output; outsiders may pull low.
// - external reset is caught without a running clock.
// - recognised external pulse is stretched to the minimum output width.
// - watchdog underflow drives the pin low for at least minimum width.
// - pin held low for as long as low-supply detector asserts.
// - low-supply threshold selectable low, medium or high by strap.
// - low-supply detector enabled or disabled by strap.
// - warning comparator shown as read-only real-time flag.
// - warning detector only works while low-supply detector enabled.
// - with enable set, every toggle of warning flag while running raises interrupt.
// - crossing during the reset delay produces no warning interrupt.
// - enabling while warning flag set gives interrupt on enable.
// - enabling after flag already cleared gives no extra interrupt.
// - all supply and clock-security bits live in one control register.
// - low-supply reset sets its flag; software writes zero to clear.
// - watchdog reset sets its flag; zero write or low-supply reset clears.
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
module reset_sequence_supply_monitor #(
  parameter int PULSE_CYC = reset_seq_pkg::RST_OUT_MIN_CYC
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  input  wire logic        reset_pin_in,
  output logic             reset_pin_out,
  output logic             reset_pin_oe_out,
  input  wire logic        wdg_underflow_in,
  input  wire logic        lsd_below_in,
  input  wire logic        warn_below_in,
  input  wire logic        opt_long_delay_in,
  input  wire logic        opt_lsd_enable_in,
  input  wire logic [1:0]  opt_lsd_level_in,
  output logic [1:0]       lsd_level_out,
  output logic             lsd_enable_out,
  output logic             cpu_reset_n_out,
  output logic             vec_fetch_out,
  output logic [15:0]      vec_addr_out,
  input  wire logic        warn_irq_ack_in,
  output logic             warn_irq_out
);
  typedef struct packed {
    reset_seq_pkg::seq_state_t state;
    logic [15:0] pulse;
    logic        fetch_n;
    logic        drive;
    logic        run;
    logic        vfetch;
    logic [15:0] vaddr;
    logic        warn_f;
    logic        warn_ie;
    logic        irq_pend;
    logic        clksec_ie;
    logic        lsd_rf;
    logic        wdg_rf;
    logic        aw_hold;
    logic [7:0]  aw_addr;
    logic        w_hold;
    logic [7:0]  w_data;
    logic        w_strb0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  seq_link_if link ();

  logic lsd_active;
  logic any_src;
  logic pulse_src;
  logic delay_enter;
  logic wr_fire;
  logic integ_wr;
  logic [reset_seq_pkg::CNT_W-1:0] delay_len;

  initial begin
    if (PULSE_CYC < 1 || PULSE_CYC > 65535) begin
      $error("reset_sequence_supply_monitor: PULSE_CYC out of range");
    end
  end

  function automatic logic [7:0] integ_view(input state_t s);
    logic [7:0] v;
    v = reset_seq_pkg::INTEG_RST;
    v[reset_seq_pkg::B_WARN_IE] = s.warn_ie;
    v[reset_seq_pkg::B_WARN_F]  = s.warn_f;
    v[reset_seq_pkg::B_LSD_RF]  = s.lsd_rf;
    v[reset_seq_pkg::B_CLKSEC_IE] = s.clksec_ie;
    v[reset_seq_pkg::B_CLKSEC_D]  = 1'b0;
    v[reset_seq_pkg::B_WDG_RF]  = s.wdg_rf;
    return v;
  endfunction

  ext_reset_catch u_catch (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_in),
    .reset_pin_in (reset_pin_in),
    .link         (link.catcher)
  );

  delay_counter #(
    .MAX_LEN (reset_seq_pkg::DELAY_LONG)
  ) u_delay (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .link     (link.counter)
  );

  assign lsd_enable_out = opt_lsd_enable_in;
  assign lsd_level_out  = opt_lsd_level_in;
  assign lsd_active     = opt_lsd_enable_in & lsd_below_in;
  assign pulse_src      = link.ext_seen | wdg_underflow_in;
  assign any_src        = pulse_src | lsd_active;
  assign delay_len      = opt_long_delay_in ?
                          reset_seq_pkg::CNT_W'(reset_seq_pkg::DELAY_LONG - 1) :
                          reset_seq_pkg::CNT_W'(reset_seq_pkg::DELAY_SHORT - 1);
  assign delay_enter    = (st_r.state == reset_seq_pkg::ST_ACTIVE) && !any_src &&
                          (st_r.pulse == 16'h0000);

  assign link.pin_drive = st_r.drive;
  assign link.ext_clear = (st_r.state == reset_seq_pkg::ST_ACTIVE) && link.ext_seen;
  assign link.cnt_load  = delay_enter;
  assign link.cnt_len   = delay_len;

  assign wr_fire  = st_r.aw_hold && st_r.w_hold && !st_r.bvalid;
  assign integ_wr = wr_fire && st_r.w_strb0 && (st_r.aw_addr == reset_seq_pkg::INTEG_OFF);

  always_comb begin
    st_nxt = st_r;
    // sequencer
    if (pulse_src) begin
      st_nxt.pulse = 16'(PULSE_CYC - 1);
    end else if (st_r.pulse != 16'h0000) begin
      st_nxt.pulse = st_r.pulse - 16'h0001;
    end
    case (st_r.state)
      reset_seq_pkg::ST_ACTIVE: begin
        if (delay_enter) begin
          st_nxt.state = reset_seq_pkg::ST_DELAY;
        end
      end
      reset_seq_pkg::ST_DELAY: begin
        if (link.cnt_done) begin
          st_nxt.state   = reset_seq_pkg::ST_FETCH;
          st_nxt.fetch_n = 1'b0;
        end
      end
      reset_seq_pkg::ST_FETCH: begin
        st_nxt.fetch_n = 1'b1;
        if (st_r.fetch_n) begin
          st_nxt.state = reset_seq_pkg::ST_RUN;
        end
      end
      reset_seq_pkg::ST_RUN: begin
        st_nxt.state = reset_seq_pkg::ST_RUN;
      end
      default: begin
        st_nxt.state = reset_seq_pkg::ST_ACTIVE;
      end
    endcase
    if (any_src) begin
      st_nxt.state = reset_seq_pkg::ST_ACTIVE;
    end
    // pin low in active and delay phases
    st_nxt.drive  = (st_nxt.state == reset_seq_pkg::ST_ACTIVE) ||
                    (st_nxt.state == reset_seq_pkg::ST_DELAY);
    st_nxt.run    = (st_nxt.state == reset_seq_pkg::ST_RUN);
    st_nxt.vfetch = (st_nxt.state == reset_seq_pkg::ST_FETCH);
    st_nxt.vaddr  = (st_nxt.state != reset_seq_pkg::ST_FETCH) ? 16'h0000 :
                    (st_nxt.fetch_n ? reset_seq_pkg::VEC_HI : reset_seq_pkg::VEC_LO);

    // warning flag only while the low-supply detector is on
    st_nxt.warn_f = opt_lsd_enable_in & warn_below_in;
    if (integ_wr) begin
      st_nxt.warn_ie   = st_r.w_data[reset_seq_pkg::B_WARN_IE];
      st_nxt.clksec_ie = st_r.w_data[reset_seq_pkg::B_CLKSEC_IE];
      if (!st_r.w_data[reset_seq_pkg::B_LSD_RF]) begin
        st_nxt.lsd_rf = 1'b0;
      end
      if (!st_r.w_data[reset_seq_pkg::B_WDG_RF]) begin
        st_nxt.wdg_rf = 1'b0;
      end
    end
    // hardware sets win over a software clear
    if (wdg_underflow_in) begin
      st_nxt.wdg_rf = 1'b1;
    end
    if (lsd_active) begin
      st_nxt.lsd_rf = 1'b1;
      st_nxt.wdg_rf = 1'b0;
    end
    // toggles while in reset are swallowed, so a fast rise gives no event
    if (warn_irq_ack_in) begin
      st_nxt.irq_pend = 1'b0;
    end
    if (st_r.warn_ie && st_r.run && (st_nxt.warn_f != st_r.warn_f)) begin
      st_nxt.irq_pend = 1'b1;
    end
    if (st_nxt.warn_ie && !st_r.warn_ie && st_r.warn_f) begin
      st_nxt.irq_pend = 1'b1;
    end

    // AXI4-Lite write side
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      st_nxt.aw_hold = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      st_nxt.w_hold  = 1'b1;
      st_nxt.w_data  = s_axi_wdata_in[7:0];
      st_nxt.w_strb0 = s_axi_wstrb_in[0];
    end
    if (wr_fire) begin
      st_nxt.aw_hold = 1'b0;
      st_nxt.w_hold  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = (st_r.aw_addr == reset_seq_pkg::INTEG_OFF ||
                        st_r.aw_addr == reset_seq_pkg::SEQ_STAT_OFF) ?
                       reset_seq_pkg::RESP_OKAY : reset_seq_pkg::RESP_SLVERR;
    end
    if (st_r.bvalid && s_axi_bready_in) begin
      st_nxt.bvalid = 1'b0;
    end
    // AXI4-Lite read side
    if (s_axi_arvalid_in && s_axi_arready_out) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = reset_seq_pkg::RESP_OKAY;
      case (s_axi_araddr_in)
        reset_seq_pkg::INTEG_OFF: begin
          st_nxt.rdata = {24'h000000, integ_view(st_r)};
        end
        reset_seq_pkg::SEQ_STAT_OFF: begin
          st_nxt.rdata = {26'h0000000, opt_lsd_level_in, opt_lsd_enable_in,
                          opt_long_delay_in, st_r.state};
        end
        default: begin
          st_nxt.rdata = 32'h00000000;
          st_nxt.rresp = reset_seq_pkg::RESP_SLVERR;
        end
      endcase
    end else if (st_r.rvalid && s_axi_rready_in) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r       <= '0;
      st_r.drive <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready_out = !st_r.aw_hold && !st_r.bvalid;
  assign s_axi_wready_out  = !st_r.w_hold && !st_r.bvalid;
  assign s_axi_bvalid_out  = st_r.bvalid;
  assign s_axi_bresp_out   = st_r.bresp;
  assign s_axi_arready_out = !st_r.rvalid;
  assign s_axi_rvalid_out  = st_r.rvalid;
  assign s_axi_rdata_out   = st_r.rdata;
  assign s_axi_rresp_out   = st_r.rresp;

  // open-drain: only ever drives low, pull-up is off chip
  assign reset_pin_out    = 1'b0;
  assign reset_pin_oe_out = st_r.drive;
  assign cpu_reset_n_out  = st_r.run;
  assign vec_fetch_out    = st_r.vfetch;
  assign vec_addr_out     = st_r.vaddr;
  assign warn_irq_out     = st_r.irq_pend & st_r.warn_ie;

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  logic [12:0] dly_seen;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dly_seen <= 13'h0000;
    end else if (st_r.state == reset_seq_pkg::ST_DELAY) begin
      dly_seen <= dly_seen + 13'h0001;
    end else begin
      dly_seen <= 13'h0000;
    end
  end

  chk_pin_in_delay: assert property (
    (st_r.state == reset_seq_pkg::ST_DELAY) |-> reset_pin_oe_out)
    else $error("pin released during delay");
  chk_delay_length: assert property (
    (st_r.state == reset_seq_pkg::ST_DELAY && st_nxt.state == reset_seq_pkg::ST_FETCH)
    |-> (dly_seen == 13'(delay_len)))
    else $error("delay phase length wrong");
  chk_fetch_two_cycles: assert property (
    (st_r.state == reset_seq_pkg::ST_FETCH && !st_r.fetch_n && !any_src)
    |=> (st_r.state == reset_seq_pkg::ST_FETCH) ##1 !vec_fetch_out)
    else $error("vector fetch not two cycles");
  chk_vector_order: assert property (
    $rose(vec_fetch_out) |-> (vec_addr_out == 16'hfffe) ##1
    (!vec_fetch_out || vec_addr_out == 16'hffff))
    else $error("vector address order wrong");
  chk_wdg_stretch: assert property (
    wdg_underflow_in |=> reset_pin_oe_out [*8])
    else $error("watchdog pulse not stretched");
  chk_source_restart: assert property (
    any_src |=> (st_r.state == reset_seq_pkg::ST_ACTIVE) && !cpu_reset_n_out)
    else $error("source did not restart sequence");
  chk_warn_gated: assert property (
    !opt_lsd_enable_in |=> !st_r.warn_f)
    else $error("warning flag active with detector off");
  chk_toggle_irq: assert property (
    (st_r.warn_ie && st_r.run && (st_nxt.warn_f != st_r.warn_f)) |=> warn_irq_out)
    else $error("toggle raised no interrupt");
  chk_no_irq_reset: assert property (
    (!st_r.run && !(st_nxt.warn_ie && !st_r.warn_ie)) |=> !$rose(st_r.irq_pend))
    else $error("interrupt raised during reset");
  chk_lsd_clears_wdg: assert property (
    lsd_active |=> st_r.lsd_rf && !st_r.wdg_rf)
    else $error("low-supply reset flags wrong");

  cov_reach_run: cover property ($rose(cpu_reset_n_out));
  cov_ext_reset: cover property ($rose(link.ext_seen) ##[1:1000] $rose(vec_fetch_out));
  cov_warn_irq: cover property ($rose(warn_irq_out));
  cov_long_delay: cover property (opt_long_delay_in && $rose(vec_fetch_out));
endmodule // reset_sequence_supply_monitor

// ---- pkg/reset_seq_pkg.sv ----
// constants, register layout and state encoding of the reset sequencer
package reset_seq_pkg;
  localparam int          CLK_MHZ         = 25;
  // minimum output reset pulse width, plain default value
  localparam int          RST_OUT_MIN_NS  = 20000;
  localparam int          RST_OUT_MIN_CYC = (RST_OUT_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int          DELAY_SHORT     = 256;
  localparam int          DELAY_LONG      = 4096;
  localparam int          FETCH_CYC       = 2;
  localparam logic [15:0] VEC_LO          = 16'hfffe;
  localparam logic [15:0] VEC_HI          = 16'hffff;
  // register byte offsets
  localparam logic [7:0]  INTEG_OFF       = 8'h00;
  localparam logic [7:0]  SEQ_STAT_OFF    = 8'h04;
  localparam logic [7:0]  INTEG_RST       = 8'h00;
  // system_integrity_ctrl_status bits
  localparam int          B_WARN_IE       = 6;
  localparam int          B_WARN_F        = 5;
  localparam int          B_LSD_RF        = 4;
  localparam int          B_CLKSEC_IE     = 2;
  localparam int          B_CLKSEC_D      = 1;
  localparam int          B_WDG_RF        = 0;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  localparam int          CNT_W           = 13;

  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b00,
    ST_DELAY  = 2'b01,
    ST_FETCH  = 2'b10,
    ST_RUN    = 2'b11
  } seq_state_t;
endpackage

// ---- pkg/seq_link_if.sv ----
// signals between the sequencer, its pin catcher and its delay counter
`timescale 1ns/100ps
interface seq_link_if;
  logic                             ext_seen;
  logic                             ext_clear;
  logic                             pin_drive;
  logic                             cnt_load;
  logic [reset_seq_pkg::CNT_W-1:0]  cnt_len;
  logic                             cnt_done;

  modport catcher (input pin_drive, input ext_clear, output ext_seen);
  modport counter (input cnt_load, input cnt_len, output cnt_done);
  modport ctrl    (input ext_seen, input cnt_done,
                   output pin_drive, output ext_clear, output cnt_load, output cnt_len);
endinterface // seq_link_if

// ---- rtl/ext_reset_catch.sv ----
// asynchronous capture of an external low on the reset pin
`timescale 1ns/100ps
module ext_reset_catch (
  input  wire logic     clk_in,
  input  wire logic     rst_n_in,
  input  wire logic     reset_pin_in,
  seq_link_if.catcher   link
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic held;
  } sync_t;

  logic  seen_r;
  logic  set_n;
  sync_t st_r;
  sync_t st_nxt;

  // own drive masked, and one cycle past release while the pull-up lifts the wire
  assign set_n = reset_pin_in | link.pin_drive | st_r.held;

  // no clock needed to catch the pin, so halted clocks still enter reset
  always_ff @(posedge clk_in or negedge rst_n_in or negedge set_n) begin
    if (!rst_n_in) begin
      seen_r <= 1'b0;
    end else if (!set_n) begin
      seen_r <= 1'b1;
    end else if (link.ext_clear) begin
      seen_r <= 1'b0;
    end
  end

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = seen_r;
    st_nxt.s2 = st_r.s1;
    st_nxt.held = link.pin_drive;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign link.ext_seen = st_r.s2;
endmodule // ext_reset_catch

// ---- rtl/delay_counter.sv ----
// load-and-count-down timer for the stabilisation delay
`timescale 1ns/100ps
module delay_counter #(
  parameter int MAX_LEN = reset_seq_pkg::DELAY_LONG
) (
  input  wire logic     clk_in,
  input  wire logic     rst_n_in,
  seq_link_if.counter   link
);
  typedef struct packed {
    logic [reset_seq_pkg::CNT_W-1:0] cnt;
  } cnt_t;

  cnt_t st_r;
  cnt_t st_nxt;

  initial begin
    if (MAX_LEN < 1 || MAX_LEN > (1 << reset_seq_pkg::CNT_W)) begin
      $error("delay_counter: MAX_LEN does not fit the counter");
    end
  end

  always_comb begin
    st_nxt = st_r;
    if (link.cnt_load) begin
      st_nxt.cnt = link.cnt_len;
    end else if (st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign link.cnt_done = (st_r.cnt == '0) && !link.cnt_load;
endmodule // delay_counter

// ---- bench/reset_wire_model.sv ----
// board side of the reset wire: pull-up plus an external reset switch
`timescale 1ns/100ps
module reset_wire_model (
  input  wire logic dut_level_in,
  input  wire logic dut_oe_in,
  output logic      wire_out
);
  logic pull_low_r = 1'b0;

  // open drain: any party pulling wins, otherwise the pull-up lifts the wire
  assign wire_out = ~((dut_oe_in & ~dut_level_in) | pull_low_r);

  // press may be shorter than a clock period, the device must still see it
  task automatic press(input int ns);
    pull_low_r = 1'b1;
    #(ns);
    pull_low_r = 1'b0;
  endtask
endmodule // reset_wire_model

// ---- bench/reset_sequence_supply_monitor_tb.sv ----
// self-checking bench for the reset sequencer and supply monitor
`timescale 1ns/100ps
module reset_sequence_supply_monitor_tb;
  localparam int         PW  = 4;
  localparam int         DS  = reset_seq_pkg::DELAY_SHORT;
  localparam logic [1:0] OK  = reset_seq_pkg::RESP_OKAY;
  localparam logic [1:0] BAD = reset_seq_pkg::RESP_SLVERR;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        wdg = 1'b0, lsd_below = 1'b0, warn_below = 1'b0, ack = 1'b0;
  logic        long_dly = 1'b0, lsd_en = 1'b1;
  logic [1:0]  lsd_lvl = 2'h2, lvl_out, bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, pin_out, pin_oe, pin_wire;
  logic        en_out, cpu_rn, vfetch, irq;
  logic [15:0] vaddr;
  int          err_total = 0;
  int          compares = 0;
  int          cyc = 0;

  always #20 clk_in = ~clk_in;

  reset_wire_model far (.dut_level_in(pin_out), .dut_oe_in(pin_oe), .wire_out(pin_wire));

  reset_sequence_supply_monitor #(.PULSE_CYC(PW)) dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .reset_pin_in(pin_wire), .reset_pin_out(pin_out),
    .reset_pin_oe_out(pin_oe), .wdg_underflow_in(wdg), .lsd_below_in(lsd_below),
    .warn_below_in(warn_below), .opt_long_delay_in(long_dly), .opt_lsd_enable_in(lsd_en),
    .opt_lsd_level_in(lsd_lvl), .lsd_level_out(lvl_out), .lsd_enable_out(en_out),
    .cpu_reset_n_out(cpu_rn), .vec_fetch_out(vfetch), .vec_addr_out(vaddr),
    .warn_irq_ack_in(ack), .warn_irq_out(irq)
  );

  task automatic stop_test();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ceiling well above the longest expected run of about 6000 cycles
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total = err_total + 1;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ready is sampled mid-cycle, it cannot change before the next edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    logic aw_hit, w_hit, b_hit;
    @(posedge clk_in);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_hit = 1'b0;
    while (!b_hit) begin
      @(negedge clk_in);
      aw_hit = awvalid & awready;
      w_hit = wvalid & wready;
      b_hit = bvalid;
      if (b_hit) chk(32'(bresp), 32'(er));
      @(posedge clk_in);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
      if (b_hit) bready <= 1'b0;
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar_hit, r_hit;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_hit = 1'b0;
    while (!r_hit) begin
      @(negedge clk_in);
      ar_hit = arvalid & arready;
      r_hit = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk_in);
      if (ar_hit) arvalid <= 1'b0;
      if (r_hit) rready <= 1'b0;
    end
    chk(d, ed);
    chk(32'(r), 32'(er));
  endtask

  // counts pin-driven cycles up to the fetch, then checks fetch and release
  task automatic seq_len(input int lo, input int hi);
    int n;
    n = 0;
    do begin
      @(negedge clk_in);
      n = n + 32'(pin_oe);
    end while (vfetch !== 1'b1 && n < 9000);
    chk(32'(n >= lo && n <= hi), 32'h1);
    chk(32'({pin_oe, cpu_rn, vaddr}), 32'(reset_seq_pkg::VEC_LO));
    @(negedge clk_in);
    chk(32'({vfetch, pin_oe, cpu_rn, vaddr}), {13'h0000, 3'h4, reset_seq_pkg::VEC_HI});
    @(negedge clk_in);
    chk(32'({vfetch, pin_oe, cpu_rn}), 32'h1);
  endtask

  task automatic reset_dut(input logic l);
    @(posedge clk_in);
    long_dly <= l;
    rst_n_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    seq_len(l ? 4096 : DS, l ? 4099 : DS + 3);
  endtask

  task automatic pulse_wdg();
    @(posedge clk_in);
    wdg <= 1'b1;
    @(posedge clk_in);
    wdg <= 1'b0;
  endtask

  task automatic irq_chk(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (6) begin
      @(negedge clk_in);
      seen = seen | irq;
    end
    chk(32'(seen), 32'(exp));
    @(posedge clk_in);
    ack <= 1'b1;
    @(posedge clk_in);
    ack <= 1'b0;
    @(negedge clk_in);
    chk(32'(irq), 32'h0);
    @(posedge clk_in);
  endtask

  task automatic t_regs();
    rd_chk(8'h00, 32'h0, OK);
    axi_wr(8'h00, 32'hffff_ff7f, 4'hf, OK);
    rd_chk(8'h00, 32'h44, OK);
    axi_wr(8'h00, 32'h0, 4'h0, OK);
    rd_chk(8'h00, 32'h44, OK);
    axi_wr(8'h00, 32'h0, 4'hf, OK);
    axi_wr(8'h08, 32'h44, 4'hf, BAD);
    rd_chk(8'h08, 32'h0, BAD);
    axi_wr(8'h04, 32'hff, 4'hf, OK);
    rd_chk(8'h04, 32'h2b, OK);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      lsd_lvl <= 2'(i);
      @(negedge clk_in);
      chk(32'({en_out, lvl_out}), 32'(4 + i));
    end
  endtask

  task automatic t_wdg();
    pulse_wdg();
    seq_len(PW + DS - 1, PW + DS + 2);
    rd_chk(8'h00, 32'h01, OK);
    axi_wr(8'h00, 32'h0, 4'hf, OK);
    rd_chk(8'h00, 32'h0, OK);
    pulse_wdg();
    repeat (PW + 100) @(posedge clk_in);
    pulse_wdg();
    seq_len(PW + DS - 1, PW + DS + 2);
  endtask

  task automatic t_lsd();
    int n;
    n = 0;
    @(posedge clk_in);
    lsd_below <= 1'b1;
    repeat (2) @(negedge clk_in);
    repeat (30) begin
      @(negedge clk_in);
      n = n + 32'(pin_oe & ~pin_wire);
    end
    chk(32'(n), 32'h1e);
    @(posedge clk_in);
    lsd_below <= 1'b0;
    seq_len(DS, DS + 3);
    rd_chk(8'h00, 32'h10, OK);
    axi_wr(8'h00, 32'h0, 4'hf, OK);
    rd_chk(8'h00, 32'h0, OK);
  endtask

  task automatic t_ext();
    @(negedge clk_in);
    #5;
    far.press(10);
    seq_len(PW + DS - 1, PW + DS + 4);
  endtask

  task automatic t_irq();
    @(posedge clk_in);
    warn_below <= 1'b1;
    rd_chk(8'h00, 32'h20, OK);
    axi_wr(8'h00, 32'h40, 4'hf, OK);
    irq_chk(1'b1);
    warn_below <= 1'b0;
    irq_chk(1'b1);
    warn_below <= 1'b1;
    irq_chk(1'b1);
    warn_below <= 1'b0;
    irq_chk(1'b1);
    axi_wr(8'h00, 32'h0, 4'hf, OK);
    axi_wr(8'h00, 32'h40, 4'hf, OK);
    irq_chk(1'b0);
    pulse_wdg();
    repeat (PW + 20) @(posedge clk_in);
    warn_below <= 1'b1;
    repeat (20) @(posedge clk_in);
    warn_below <= 1'b0;
    // 44 cycles of this sequence already passed before counting starts
    seq_len(PW + DS - 45, PW + DS - 42);
    irq_chk(1'b0);
  endtask

  task automatic t_off();
    @(posedge clk_in);
    lsd_en <= 1'b0;
    lsd_below <= 1'b1;
    warn_below <= 1'b1;
    irq_chk(1'b0);
    @(negedge clk_in);
    chk(32'({pin_oe, cpu_rn, en_out}), 32'h2);
    rd_chk(8'h00, 32'h41, OK);
    lsd_below <= 1'b0;
    warn_below <= 1'b0;
    lsd_en <= 1'b1;
  endtask

  initial begin
    reset_dut(1'b0);
    t_regs();
    t_wdg();
    t_lsd();
    t_ext();
    t_irq();
    t_off();
    reset_dut(1'b1);
    stop_test();
  end
endmodule // reset_sequence_supply_monitor_tb
